// ===== design/tfw_pkg.sv
// Package of constants for the track format writer.
// Overview of operation
// RULE_01 - Host uses 128, 256, 512, 1024-byte sectors
// RULE_02 - Standard layouts: FM 128, MFM 256 bytes
// RULE_03 - Byte F7 writes the two CRC bytes
// RULE_04 - MFM byte F5 writes mark A1
// RULE_05 - MFM byte F6 writes mark C2
// RULE_06 - ID field: FE, track, side, sector, length, CRC
// RULE_07 - Data field: FB, data, CRC request
// RULE_08 - Length code 00 is 128, 01 is 256
// RULE_09 - Gap after ID has exact byte counts
// RULE_10 - Other gaps have minimum filler counts
// RULE_11 - MFM data gap: 8 zeros, exactly three marks
// RULE_12 - Host sends 4E until track completes
// RULE_13 - Build option selects host data polarity
// RULE_14 - Single-density variant ignores density select
// RULE_15 - Density select low means double density
// RULE_16 - CRC polynomial x16+x12+x5+1
package tfw_pkg;
	localparam logic [7:0]  CRC_REQ_BYTE  = 8'hF7;
	localparam logic [7:0]  MFM_A1_REQ    = 8'hF5;
	localparam logic [7:0]  MFM_C2_REQ    = 8'hF6;
	localparam logic [7:0]  MFM_A1_BYTE   = 8'hA1;
	localparam logic [7:0]  MFM_C2_BYTE   = 8'hC2;
	localparam logic [7:0]  IDX_MARK      = 8'hFC;
	localparam logic [7:0]  ID_MARK       = 8'hFE;
	localparam logic [7:0]  DATA_MARK     = 8'hFB;
	localparam logic [7:0]  DEL_MARK      = 8'hF8;
	localparam logic [7:0]  FM_FILL       = 8'hFF;
	localparam logic [7:0]  MFM_FILL      = 8'h4E;
	localparam logic [15:0] CRC_POLY      = 16'h1021;
	localparam logic [15:0] CRC_INIT      = 16'hFFFF;
	localparam logic [15:0] CRC_MFM_PRE   = 16'hCDB4;
	localparam logic [7:0]  FM_IDX_CLK    = 8'hD7;
	localparam logic [7:0]  FM_AM_CLK     = 8'hC7;
	localparam logic [7:0]  FM_DATA_CLK   = 8'hFF;
	localparam logic [7:0]  ZERO_BYTE     = 8'h00;
	localparam int          BYTE_BITS     = 8;
	typedef enum logic [1:0] {TFW_IDLE, TFW_BYTE, TFW_CRC_HI, TFW_CRC_LO} tfw_state_type;
endpackage : tfw_pkg

// ===== design/tfw_crc16.sv
// CRC-16 byte update step for the track format writer.
`timescale 1ns/1ps
module tfw_crc16 (
	// Running value and byte in
	input  wire logic [15:0] crc_i,
	input  wire logic [7:0]  data_i,
	// Updated value
	output logic      [15:0] crc_o
);
	always_comb begin
		logic [15:0] c;
		c = crc_i;
		for (int i = tfw_pkg::BYTE_BITS - 1; i >= 0; i--) begin
			if (c[15] ^ data_i[i]) begin
				c = {c[14:0], 1'b0} ^ tfw_pkg::CRC_POLY; // RULE_16
			end else begin
				c = {c[14:0], 1'b0};
			end
		end
		crc_o = c;
	end
endmodule : tfw_crc16

// ===== design/tfw_track_writer.sv
// Whole-track byte translator with CRC insertion for the track format writer.
`timescale 1ns/1ps
module tfw_track_writer #(
	parameter bit DATA_INVERTED = 1'b0,
	parameter bit FM_ONLY       = 1'b0
) (
	// Clock and reset
	input  wire logic       sys_clk_i,
	input  wire logic       rst_n_i,
	// Command control
	input  wire logic       track_start_i,
	input  wire logic       track_done_i,
	input  wire logic       density_select_n_i,
	// Host byte stream
	input  wire logic [7:0] host_data_lines_i,
	input  wire logic       host_valid_i,
	output logic            host_ready_o,
	// Encoded byte stream to the serialiser
	output logic [7:0]      disk_byte_o,
	output logic [7:0]      disk_clk_pat_o,
	output logic            disk_missing_clk_o,
	output logic            disk_valid_o,
	input  wire logic       disk_ready_i,
	// Status
	output logic            busy_o,
	output logic            mfm_mode_o,
	output logic            completion_interrupt_o
);
	tfw_pkg::tfw_state_type state_r;
	tfw_pkg::tfw_state_type state_nxt;
	logic [15:0]            crc_r;
	logic [15:0]            crc_nxt;
	logic [15:0]            crc_upd;
	logic [15:0]            crc_seed;
	logic [7:0]             byte_r;
	logic [7:0]             byte_nxt;
	logic [7:0]             clk_r;
	logic [7:0]             clk_nxt;
	logic                   miss_r;
	logic                   miss_nxt;
	logic                   valid_r;
	logic                   valid_nxt;
	logic                   mfm_r;
	logic                   mfm_nxt;
	logic                   irq_r;
	logic                   irq_nxt;
	logic                   dens_s1_r;
	logic                   dens_s2_r;
	logic [7:0]             host_byte;
	logic [7:0]             crc_in;
	logic                   take;
	logic                   emit_free;
	logic                   is_crc_req;
	logic                   is_a1_req;
	logic                   is_c2_req;
	logic                   is_fm_idx;
	logic                   is_fm_am;

	// The density pin is asynchronous, so it is resynchronised first.
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			dens_s1_r <= 1'b1;
			dens_s2_r <= 1'b1;
		end else begin
			dens_s1_r <= density_select_n_i;
			dens_s2_r <= dens_s1_r;
		end
	end

	assign host_byte = DATA_INVERTED ? ~host_data_lines_i : host_data_lines_i; // RULE_13
	assign emit_free = !valid_r || disk_ready_i;
	assign take      = (state_r == tfw_pkg::TFW_BYTE) && host_valid_i && emit_free && !track_done_i;
	assign host_ready_o = (state_r == tfw_pkg::TFW_BYTE) && emit_free && !track_done_i;
	assign crc_in    = host_byte;

	assign is_crc_req = (host_byte == tfw_pkg::CRC_REQ_BYTE);
	assign is_a1_req  = mfm_r && (host_byte == tfw_pkg::MFM_A1_REQ);
	assign is_c2_req  = mfm_r && (host_byte == tfw_pkg::MFM_C2_REQ);
	assign is_fm_idx  = !mfm_r && (host_byte == tfw_pkg::IDX_MARK);
	assign is_fm_am   = !mfm_r && (host_byte == tfw_pkg::ID_MARK || host_byte == tfw_pkg::DATA_MARK
		|| host_byte == tfw_pkg::DEL_MARK);
	// An FM address mark restarts the CRC, so its update starts from the preset and not from the gap bytes.
	assign crc_seed   = is_fm_am ? tfw_pkg::CRC_INIT : crc_r;

	tfw_crc16 u_crc (
		.crc_i  (crc_seed),
		.data_i (crc_in),
		.crc_o  (crc_upd)
	);

	always_comb begin
		state_nxt = state_r;
		crc_nxt   = crc_r;
		byte_nxt  = byte_r;
		clk_nxt   = clk_r;
		miss_nxt  = miss_r;
		valid_nxt = valid_r && !disk_ready_i;
		unique case (state_r)
			tfw_pkg::TFW_IDLE: begin
				if (track_start_i) begin
					crc_nxt   = tfw_pkg::CRC_INIT;
					state_nxt = tfw_pkg::TFW_BYTE;
				end
			end
			tfw_pkg::TFW_BYTE: begin
				if (take) begin
					valid_nxt = 1'b1;
					byte_nxt  = host_byte;
					clk_nxt   = tfw_pkg::FM_DATA_CLK;
					miss_nxt  = 1'b0;
					crc_nxt   = crc_upd;
					if (is_crc_req) begin
						// The request byte itself is never written, so the output slot stays empty.
						valid_nxt = 1'b0;
						crc_nxt   = crc_r;
						state_nxt = tfw_pkg::TFW_CRC_HI; // RULE_03
					end else if (is_a1_req) begin
						byte_nxt  = tfw_pkg::MFM_A1_BYTE; // RULE_04
						miss_nxt  = 1'b1;
						// Three marks always leave the same CRC, so that value is loaded at once.
						crc_nxt   = tfw_pkg::CRC_MFM_PRE;
					end else if (is_c2_req) begin
						byte_nxt  = tfw_pkg::MFM_C2_BYTE; // RULE_05
						miss_nxt  = 1'b1;
						crc_nxt   = crc_r;
					end else if (is_fm_idx) begin
						clk_nxt   = tfw_pkg::FM_IDX_CLK;
						miss_nxt  = 1'b1;
						crc_nxt   = crc_r;
					end else if (is_fm_am) begin
						clk_nxt   = tfw_pkg::FM_AM_CLK;
						miss_nxt  = 1'b1;
					end
				end
			end
			tfw_pkg::TFW_CRC_HI: begin
				if (emit_free) begin
					valid_nxt = 1'b1;
					byte_nxt  = crc_r[15:8]; // RULE_03
					clk_nxt   = tfw_pkg::FM_DATA_CLK;
					miss_nxt  = 1'b0;
					state_nxt = tfw_pkg::TFW_CRC_LO;
				end
			end
			tfw_pkg::TFW_CRC_LO: begin
				if (emit_free) begin
					valid_nxt = 1'b1;
					byte_nxt  = crc_r[7:0]; // RULE_03
					crc_nxt   = tfw_pkg::CRC_INIT;
					state_nxt = tfw_pkg::TFW_BYTE;
				end
			end
		endcase
		// The track end also cuts a pending CRC pair short, since the head has reached the index.
		if (state_r != tfw_pkg::TFW_IDLE && track_done_i) begin
			state_nxt = tfw_pkg::TFW_IDLE; // RULE_12
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			state_r <= tfw_pkg::TFW_IDLE;
			crc_r   <= tfw_pkg::CRC_INIT;
			byte_r  <= tfw_pkg::ZERO_BYTE;
			clk_r   <= tfw_pkg::ZERO_BYTE;
			miss_r  <= 1'b0;
			valid_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			crc_r   <= crc_nxt;
			byte_r  <= byte_nxt;
			clk_r   <= clk_nxt;
			miss_r  <= miss_nxt;
			valid_r <= valid_nxt;
		end
	end

	always_comb begin
		mfm_nxt = mfm_r;
		irq_nxt = irq_r;
		if (state_r == tfw_pkg::TFW_IDLE && track_start_i) begin
			// Density is latched per track; changing it mid-track would corrupt encoding.
			mfm_nxt = FM_ONLY ? 1'b0 : !dens_s2_r; // RULE_14 RULE_15
			irq_nxt = 1'b0;
		end else if (state_r != tfw_pkg::TFW_IDLE && track_done_i) begin
			irq_nxt = 1'b1; // RULE_12
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			mfm_r <= 1'b0;
			irq_r <= 1'b0;
		end else begin
			mfm_r <= mfm_nxt;
			irq_r <= irq_nxt;
		end
	end

	assign disk_byte_o            = byte_r;
	assign disk_clk_pat_o         = clk_r;
	assign disk_missing_clk_o     = miss_r;
	assign disk_valid_o           = valid_r;
	assign busy_o                 = (state_r != tfw_pkg::TFW_IDLE);
	assign mfm_mode_o             = mfm_r;
	assign completion_interrupt_o = irq_r;
endmodule : tfw_track_writer

// ===== dv/tfw_chk.sv
// Port checker for the track format writer.
`timescale 1ns/1ps
module tfw_chk #(
	parameter bit DATA_INVERTED = 1'b0,
	parameter bit FM_ONLY       = 1'b0
) (
	// Clock and reset
	input wire logic       sys_clk_i,
	input wire logic       rst_n_i,
	// Command control
	input wire logic       track_start_i,
	input wire logic       track_done_i,
	// Host byte stream
	input wire logic [7:0] host_data_lines_i,
	input wire logic       host_valid_i,
	input wire logic       host_ready_o,
	// Encoded byte stream
	input wire logic [7:0] disk_byte_o,
	input wire logic       disk_valid_o,
	input wire logic       disk_ready_i,
	// Status
	input wire logic       busy_o,
	input wire logic       mfm_mode_o,
	input wire logic       completion_interrupt_o
);
	wire logic [7:0] hb = DATA_INVERTED ? ~host_data_lines_i : host_data_lines_i;
	wire logic       tk = host_valid_i && host_ready_o;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	mark_a1_a: assert property (tk && hb == 8'hF5 && mfm_mode_o |=> disk_valid_o && disk_byte_o == 8'hA1)
		else $error("F5 not written as A1");
	mark_c2_a: assert property (tk && hb == 8'hF6 && mfm_mode_o |=> disk_valid_o && disk_byte_o == 8'hC2)
		else $error("F6 not written as C2");
	crc_emit_a: assert property (tk && hb == 8'hF7 |=> !host_ready_o ##1 disk_valid_o)
		else $error("CRC request not followed by CRC bytes");
	done_irq_a: assert property (track_done_i && busy_o |-> ##[1:3] completion_interrupt_o)
		else $error("Completion flag not raised");
	irq_hold_a: assert property (completion_interrupt_o && !track_start_i |=> completion_interrupt_o)
		else $error("Completion flag dropped early");
	done_refuse_a: assert property (track_done_i |-> !host_ready_o)
		else $error("Byte accepted at track end");
	disk_hold_a: assert property (disk_valid_o && !disk_ready_i |=> disk_valid_o && $stable(disk_byte_o))
		else $error("Disk byte changed while stalled");
	mode_hold_a: assert property (busy_o && $past(busy_o) |-> $stable(mfm_mode_o))
		else $error("Density changed during command");
	fm_only_a: assert property (FM_ONLY && busy_o |-> !mfm_mode_o)
		else $error("Single-density variant entered double density");
	crc_c: cover property (tk && hb == 8'hF7);
	done_c: cover property (track_done_i && busy_o);
	stall_c: cover property (disk_valid_o && !disk_ready_i);
	mark_c: cover property (tk && hb == 8'hF5 && mfm_mode_o);
endmodule : tfw_chk
bind tfw_track_writer tfw_chk #(.DATA_INVERTED(DATA_INVERTED), .FM_ONLY(FM_ONLY)) tfw_chk_i (
	.sys_clk_i              (sys_clk_i),
	.rst_n_i                (rst_n_i),
	.track_start_i          (track_start_i),
	.track_done_i           (track_done_i),
	.host_data_lines_i      (host_data_lines_i),
	.host_valid_i           (host_valid_i),
	.host_ready_o           (host_ready_o),
	.disk_byte_o            (disk_byte_o),
	.disk_valid_o           (disk_valid_o),
	.disk_ready_i           (disk_ready_i),
	.busy_o                 (busy_o),
	.mfm_mode_o             (mfm_mode_o),
	.completion_interrupt_o (completion_interrupt_o)
);

// ===== dv/tfw_disk_model.sv
// Serialiser model that takes encoded bytes with random stalls.
`timescale 1ns/1ps
module tfw_disk_model (
	// Clock and handshake
	input  wire logic sys_clk_i,
	output logic      disk_ready_o
);
	// Stalls about one cycle in four, so held disk bytes are exercised.
	initial disk_ready_o = 1'b0;
	always @(posedge sys_clk_i) disk_ready_o <= ($urandom % 4) != 0;
endmodule : tfw_disk_model

// ===== dv/tfw_track_writer_tb.sv
// Self-checking testbench for the track format writer.
`timescale 1ns/1ps
module tfw_track_writer_tb;
	logic        sys_clk_i = 0, rst_n_i = 0, track_start_i = 0, track_done_i = 0, density_select_n_i = 0;
	logic        host_valid_i = 0, disk_ready_i, mfm;
	logic [7:0]  host_data_lines_i = 8'h00, last, fill;
	logic [16:0] exp_q[$], exp_e;
	logic [15:0] crc;
	wire         host_ready_o, disk_missing_clk_o, disk_valid_o, busy_o, mfm_mode_o, completion_interrupt_o;
	wire  [7:0]  disk_byte_o, disk_clk_pat_o;
	wire         fm_ready, fm_miss, fm_valid, fm_busy, fm_mode, fm_irq;
	wire  [7:0]  fm_byte, fm_clk;
	int          n_mismatch = 0, checks_done = 0;
	tfw_track_writer #(.FM_ONLY(1'b0)) tfw_track_writer_i (.*);
	// The FM-only build with inverted host lines sees the same traffic, so in FM tracks it must match.
	tfw_track_writer #(.DATA_INVERTED(1'b1), .FM_ONLY(1'b1)) tfw_track_writer_fm_i (
		.sys_clk_i              (sys_clk_i),
		.rst_n_i                (rst_n_i),
		.track_start_i          (track_start_i),
		.track_done_i           (track_done_i),
		.density_select_n_i     (density_select_n_i),
		.host_data_lines_i      (~host_data_lines_i),
		.host_valid_i           (host_valid_i),
		.host_ready_o           (fm_ready),
		.disk_byte_o            (fm_byte),
		.disk_clk_pat_o         (fm_clk),
		.disk_missing_clk_o     (fm_miss),
		.disk_valid_o           (fm_valid),
		.disk_ready_i           (disk_ready_i),
		.busy_o                 (fm_busy),
		.mfm_mode_o             (fm_mode),
		.completion_interrupt_o (fm_irq)
	);
	tfw_disk_model tfw_disk_model_i (.sys_clk_i(sys_clk_i), .disk_ready_o(disk_ready_i));
	initial forever #12.5 sys_clk_i = ~sys_clk_i;
	task complete_run;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [23:0] s, e);
		checks_done++;
		if (s !== e) begin
			n_mismatch++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task put(input logic [7:0] b, input logic [8:0] c);
		for (int i = 0; i < 8; i++) crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ b[7-i]) ? 16'h1021 : 16'h0000);
		exp_q.push_back({c, b});
	endtask : put
	task send(input logic [7:0] b);
		int         k;
		logic [8:0] c;
		k = 0;
		c = 9'h0FF;
		host_data_lines_i <= b;
		host_valid_i <= 1'b1;
		do @(negedge sys_clk_i); while (host_ready_o !== 1'b1 && ++k < 500);
		if (k >= 500) begin
			n_mismatch++;
			complete_run;
		end
		@(posedge sys_clk_i);
		// Marks carry a missing clock; in FM the index mark and the address marks use different patterns.
		if (mfm && (b == 8'hF5 || b == 8'hF6)) c = 9'h1FF;
		if (!mfm && b == 8'hFC) c = 9'h1D7;
		if (!mfm && (b == 8'hFE || b == 8'hFB)) c = 9'h1C7;
		// The first F5 of a run and the FM FE and FB marks restart the running CRC so earlier gap bytes never reach it.
		if (b == 8'hF5 && last != 8'hF5 || !mfm && (b == 8'hFE || b == 8'hFB)) crc = 16'hFFFF;
		if (b == 8'hF7) begin
			exp_q.push_back({9'h0FF, crc[15:8]});
			exp_q.push_back({9'h0FF, crc[7:0]});
			crc = 16'hFFFF;
		end else put(mfm && b == 8'hF5 ? 8'hA1 : mfm && b == 8'hF6 ? 8'hC2 : b, c);
		last = b;
	endtask : send
	task fld(input logic [7:0] m, input int n);
		if (mfm) repeat (3) send(8'hF5);
		send(m);
		if (m == 8'hFE) begin
			send(8'($urandom % 77));
			send(8'($urandom % 2));
			send(8'(1 + $urandom % 26));
			send(8'(mfm));
		end else repeat (n) send(8'($urandom % 240));
		send(8'hF7);
	endtask : fld
	task trk(input bit m);
		int k;
		density_select_n_i <= !m;
		repeat (4) @(posedge sys_clk_i);
		track_start_i <= 1'b1;
		@(posedge sys_clk_i);
		track_start_i <= 1'b0;
		mfm = m;
		fill = m ? 8'h4E : 8'hFF;
		crc = 16'hFFFF;
		last = 8'h00;
		repeat (2) @(posedge sys_clk_i);
		chk(mfm_mode_o, m);
		chk(completion_interrupt_o, 0);
		chk(fm_mode, 0);
		repeat (16) send(fill);
		repeat (m ? 12 : 6) send(8'h00);
		if (m) repeat (3) send(8'hF6);
		send(8'hFC);
		repeat (16) send(fill);
		repeat (m ? 12 : 6) send(8'h00);
		repeat (2) begin
			fld(8'hFE, 0);
			repeat (m ? 22 : 11) send(fill);
			repeat (m ? 12 : 6) send(8'h00);
			fld(8'hFB, m ? 256 : 128);
			repeat (16) send(fill);
			repeat (m ? 8 : 4) send(8'h00);
		end
		repeat (16) send(fill);
		host_valid_i <= 1'b0;
		k = 0;
		while (exp_q.size() != 0 && ++k < 3000) @(posedge sys_clk_i);
		chk(k < 3000, 1);
		track_done_i <= 1'b1;
		@(posedge sys_clk_i);
		track_done_i <= 1'b0;
		repeat (4) @(posedge sys_clk_i);
		chk(completion_interrupt_o, 1);
		chk({busy_o, host_ready_o, fm_busy, fm_ready}, 0);
		chk({completion_interrupt_o, fm_irq}, 2'b11);
		$display("track test done, double density %0d", m);
	endtask : trk
	always @(posedge sys_clk_i)
		if (rst_n_i && disk_valid_o && disk_ready_i) begin
			exp_e = exp_q.size() ? exp_q.pop_front() : 17'h1_DEAD;
			chk({disk_missing_clk_o, disk_clk_pat_o, disk_byte_o}, exp_e);
			if (!mfm) chk({fm_valid, fm_miss, fm_clk, fm_byte}, {1'b1, exp_e});
		end
	initial begin
		void'($urandom(63));
		repeat (10) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		trk(1'b1);
		trk(1'b0);
		trk(1'b1);
		complete_run;
	end
endmodule : tfw_track_writer_tb
